// [include/sac_params.svh]
// Timing counts, widths and reset values for the conversion sequencer
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_DATA_BITS        10
`define SAC_UPPER_BITS       8
`define SAC_LOWER_BITS       2
`define SAC_PIN_COUNT        5

// Pin positions inside the synchroniser vector
`define SAC_PIN_START        0
`define SAC_PIN_COMP         1
`define SAC_PIN_RANGE        2
`define SAC_PIN_UPPER_EN_N   3
`define SAC_PIN_LOWER_EN_N   4

`define SAC_RESULT_RESET     10'h000
`define SAC_TOP_BIT          10'h200

// ref_clk rate
`define SAC_CLK_MHZ          50

// Least start-pulse width, rounded up to whole cycles
`define SAC_START_MIN_NS     500
`define SAC_START_MIN_CYCLES ((`SAC_START_MIN_NS * `SAC_CLK_MHZ + 999) / 1000)

// Longest time from start rise to ready high, rounded down
`define SAC_CLEAR_MAX_NS     1500
`define SAC_CLEAR_MAX_CYCLES ((`SAC_CLEAR_MAX_NS * `SAC_CLK_MHZ) / 1000)

// Settling time given to each trial bit before the comparator is read
`define SAC_BIT_TIME_NS      2000
`define SAC_BIT_CYCLES       ((`SAC_BIT_TIME_NS * `SAC_CLK_MHZ) / 1000)

`define SAC_TIMER_BITS       8
`define SAC_WIDTH_BITS       6

`endif

// [include/sac_pkg.sv]
// Types shared by the conversion sequencer
`default_nettype none

package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE      = 2'b00,
        SAC_WAIT_FALL = 2'b01,
        SAC_TRIAL     = 2'b10,
        SAC_DONE      = 2'b11
    } sac_state_e;

    typedef logic [9:0] sac_word_t;

endpackage : sac_pkg

`default_nettype wire

// [core/sac_sync.sv]
// Two-flop synchroniser for a group of asynchronous pins
`default_nettype none

module sac_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end

endmodule : sac_sync

`default_nettype wire

// [core/sac_sequencer.sv]
// Successive-approximation conversion sequencer with byte-group output buffers
//
// How it works
// - Start rise clears the search and raises ready within 1.5 us.
// - The search begins on the falling edge of start, not the rise.
// - Trial bits run from bit nine down to bit zero, one at a time.
// - Each trial bit is set, then cleared if the comparator reports overshoot.
// - After bit zero is decided, ready goes low: result available.
// - Low upper enable drives eight high bits; low lower enable drives two low bits.
// - Bipolar mode injects the offset, giving offset binary; unipolar gives plain binary.
// - Bipolar mid-scale input yields one followed by nine zeros.
`default_nettype none
`include "sac_params.svh"

module sac_sequencer (
    input  wire logic                        ref_clk,
    input  wire logic                        nrst,
    input  wire logic                        start_pin,
    input  wire logic                        comparator_over,
    input  wire logic                        range_open,
    input  wire logic                        upper_group_enable_n,
    input  wire logic                        lower_group_enable_n,
    output logic                             result_valid_n,
    output logic      [`SAC_UPPER_BITS-1:0]  upper_data,
    output logic                             upper_data_oe,
    output logic      [`SAC_LOWER_BITS-1:0]  lower_data,
    output logic                             lower_data_oe,
    output logic      [`SAC_DATA_BITS-1:0]   dac_code,
    output logic                             bipolar_offset_on,
    output logic                             conv_busy,
    output logic                             start_too_short
);

    // =====================================================================
    // Pin synchronisation
    // =====================================================================
    logic [`SAC_PIN_COUNT-1:0] pins_raw;
    logic [`SAC_PIN_COUNT-1:0] pins_sync;

    assign pins_raw = {lower_group_enable_n, upper_group_enable_n, range_open,
                       comparator_over, start_pin};

    sac_sync #(
        .WIDTH    (`SAC_PIN_COUNT)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    logic start_s;
    logic comp_s;
    logic range_s;
    logic upper_en_n_s;
    logic lower_en_n_s;

    assign start_s      = pins_sync[`SAC_PIN_START];
    assign comp_s       = pins_sync[`SAC_PIN_COMP];
    assign range_s      = pins_sync[`SAC_PIN_RANGE];
    assign upper_en_n_s = pins_sync[`SAC_PIN_UPPER_EN_N];
    assign lower_en_n_s = pins_sync[`SAC_PIN_LOWER_EN_N];

    // =====================================================================
    // Start edge detection and pulse width check
    // =====================================================================
    logic start_d_reg;
    logic start_rise;
    logic start_fall;

    assign start_rise = start_s & ~start_d_reg;
    assign start_fall = ~start_s & start_d_reg;

    logic [`SAC_WIDTH_BITS-1:0] width_cnt_reg;
    logic [`SAC_WIDTH_BITS-1:0] width_cnt_next;
    logic                       width_full;
    logic                       short_next;

    localparam logic [`SAC_WIDTH_BITS-1:0] START_MIN =
        `SAC_WIDTH_BITS'(`SAC_START_MIN_CYCLES);

    // Counter saturates so a long pulse cannot wrap into a false short flag
    assign width_full     = (width_cnt_reg >= START_MIN);
    assign width_cnt_next = start_rise ? `SAC_WIDTH_BITS'(1) :
                            (start_s && !width_full) ? width_cnt_reg + `SAC_WIDTH_BITS'(1) :
                            width_cnt_reg;
    // Flag is only a diagnostic; a short pulse still starts a conversion
    assign short_next     = start_fall ? !width_full :
                            start_rise ? 1'b0 : start_too_short;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            start_d_reg     <= 1'b0;
            width_cnt_reg   <= '0;
            start_too_short <= 1'b0;
        end else begin
            start_d_reg     <= start_s;
            width_cnt_reg   <= width_cnt_next;
            start_too_short <= short_next;
        end
    end

    // =====================================================================
    // Search state machine
    // =====================================================================
    localparam logic [`SAC_TIMER_BITS-1:0] BIT_LOAD =
        `SAC_TIMER_BITS'(`SAC_BIT_CYCLES - 1);

    sac_pkg::sac_state_e       state_reg;
    sac_pkg::sac_state_e       state_next;
    sac_pkg::sac_word_t        approximation_register;
    sac_pkg::sac_word_t        approx_next;
    sac_pkg::sac_word_t        trial_reg;
    sac_pkg::sac_word_t        trial_next;
    sac_pkg::sac_word_t        approx_decided;
    logic [`SAC_TIMER_BITS-1:0] timer_reg;
    logic [`SAC_TIMER_BITS-1:0] timer_next;
    logic                      valid_n_next;
    logic                      busy_next;
    logic                      offset_next;
    logic                      timer_done;

    assign timer_done     = (timer_reg == '0);
    // Overshoot turns the trial bit back off
    assign approx_decided = comp_s ? (approximation_register & ~trial_reg)
                                   : approximation_register;

    always_comb begin
        state_next   = state_reg;
        approx_next  = approximation_register;
        trial_next   = trial_reg;
        timer_next   = timer_reg;
        valid_n_next = result_valid_n;
        busy_next    = conv_busy;
        offset_next  = bipolar_offset_on;
        if (start_rise) begin
            // Clear is done a few cycles after the pin rises, well inside the limit
            state_next   = sac_pkg::SAC_WAIT_FALL;
            approx_next  = `SAC_RESULT_RESET;
            trial_next   = '0;
            timer_next   = '0;
            valid_n_next = 1'b1;
            busy_next    = 1'b0;
        end else begin
            case (state_reg)
                sac_pkg::SAC_IDLE: begin
                    state_next = sac_pkg::SAC_IDLE;
                end
                sac_pkg::SAC_WAIT_FALL: begin
                    if (start_fall) begin
                        state_next  = sac_pkg::SAC_TRIAL;
                        approx_next = `SAC_TOP_BIT;
                        trial_next  = `SAC_TOP_BIT;
                        timer_next  = BIT_LOAD;
                        busy_next   = 1'b1;
                        // Open pin reads high: bipolar; grounded: unipolar
                        offset_next = range_s;
                    end
                end
                sac_pkg::SAC_TRIAL: begin
                    if (!timer_done) begin
                        timer_next = timer_reg - `SAC_TIMER_BITS'(1);
                    end else if (trial_reg[0]) begin
                        state_next   = sac_pkg::SAC_DONE;
                        approx_next  = approx_decided;
                        trial_next   = '0;
                        valid_n_next = 1'b0;
                        busy_next    = 1'b0;
                    end else begin
                        approx_next = approx_decided | (trial_reg >> 1);
                        trial_next  = trial_reg >> 1;
                        timer_next  = BIT_LOAD;
                    end
                end
                sac_pkg::SAC_DONE: begin
                    state_next = sac_pkg::SAC_DONE;
                end
                default: begin
                    state_next = sac_pkg::SAC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg              <= sac_pkg::SAC_IDLE;
            approximation_register <= `SAC_RESULT_RESET;
            trial_reg              <= '0;
            timer_reg              <= '0;
            result_valid_n         <= 1'b1;
            conv_busy              <= 1'b0;
            bipolar_offset_on      <= 1'b0;
        end else begin
            state_reg              <= state_next;
            approximation_register <= approx_next;
            trial_reg              <= trial_next;
            timer_reg              <= timer_next;
            result_valid_n         <= valid_n_next;
            conv_busy              <= busy_next;
            bipolar_offset_on      <= offset_next;
        end
    end

    // =====================================================================
    // Trial code to the DAC and output buffers
    // =====================================================================
    // Data lines always mirror the register; the enables decide whether they reach the bus
    assign dac_code   = approximation_register;
    assign upper_data = approximation_register[`SAC_DATA_BITS-1:`SAC_LOWER_BITS];
    assign lower_data = approximation_register[`SAC_LOWER_BITS-1:0];

    // Enables left low during a conversion show trial bits; floating them is the host's job
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            upper_data_oe <= 1'b0;
            lower_data_oe <= 1'b0;
        end else begin
            upper_data_oe <= ~upper_en_n_s;
            lower_data_oe <= ~lower_en_n_s;
        end
    end

endmodule : sac_sequencer

`default_nettype wire

// [verif/sac_seq_checker.sv]
// Port assertions for the conversion sequencer
`default_nettype none
// ==============================
// Checker
module sac_seq_checker (
    input wire logic               ref_clk,
    input wire logic               nrst,
    input wire logic               start_pin,
    input wire logic               comparator_over,
    input wire logic               range_open,
    input wire logic               upper_group_enable_n,
    input wire logic               lower_group_enable_n,
    input wire logic               result_valid_n,
    input wire logic [7:0]         upper_data,
    input wire logic               upper_data_oe,
    input wire logic [1:0]         lower_data,
    input wire logic               lower_data_oe,
    input wire sac_pkg::sac_word_t dac_code,
    input wire logic               bipolar_offset_on,
    input wire logic               conv_busy,
    input wire logic               start_too_short
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Enables pass a two-flop synchroniser, so four samples cover the lag
    sequence s_up_low; !upper_group_enable_n [*4]; endsequence
    sequence s_lo_low; !lower_group_enable_n [*4]; endsequence
    sequence s_held; !result_valid_n && !$past(result_valid_n); endsequence
    AST_READY_CLEAR: assert property ($rose(start_pin) |-> ##[1:75] result_valid_n)
        else $error("ready not high after start rise");
    AST_NO_RISE_START: assert property (start_pin [*8] |-> !conv_busy)
        else $error("search running while start high");
    AST_MSB_FIRST: assert property ($rose(conv_busy) |->
        dac_code == 10'h200 && bipolar_offset_on == range_open)
        else $error("search did not open on top bit");
    AST_BIT_SETTLE: assert property (conv_busy && $changed(dac_code) && !start_pin
        |=> $stable(dac_code) [*8])
        else $error("trial word changed too soon");
    AST_READY_AT_END: assert property ($fell(result_valid_n) |-> $fell(conv_busy))
        else $error("ready fell outside search end");
    AST_UPPER_ON: assert property (s_up_low |-> upper_data_oe)
        else $error("upper group not driven");
    AST_UPPER_OFF: assert property (upper_group_enable_n [*4] |-> !upper_data_oe)
        else $error("upper group driven while disabled");
    AST_LOWER_ON: assert property (s_lo_low |-> lower_data_oe)
        else $error("lower group not driven");
    AST_LOWER_OFF: assert property (lower_group_enable_n [*4] |-> !lower_data_oe)
        else $error("lower group driven while disabled");
    AST_RESULT_HOLD: assert property (s_held |->
        $stable(dac_code) && {upper_data, lower_data} == dac_code)
        else $error("held result moved");
endmodule : sac_seq_checker

bind sac_sequencer sac_seq_checker u_chk (.ref_clk(ref_clk), .nrst(nrst),
    .start_pin(start_pin), .comparator_over(comparator_over), .range_open(range_open),
    .upper_group_enable_n(upper_group_enable_n), .lower_group_enable_n(lower_group_enable_n),
    .result_valid_n(result_valid_n), .upper_data(upper_data), .upper_data_oe(upper_data_oe),
    .lower_data(lower_data), .lower_data_oe(lower_data_oe), .dac_code(dac_code),
    .bipolar_offset_on(bipolar_offset_on), .conv_busy(conv_busy),
    .start_too_short(start_too_short));
`default_nettype wire

// [verif/sac_far_model.sv]
// Analog far side: ideal comparator against a held input level
`default_nettype none
// ==============================
// Comparator model
module sac_far_model (
    input  wire sac_pkg::sac_word_t dac_code,
    input  wire logic               bipolar_offset_on,
    input  wire logic signed [10:0] level,
    output logic                    comparator_over
);
    logic signed [11:0] eff;
    // Offset injection shifts a signed level up by half scale
    assign eff = level + (bipolar_offset_on ? 12'sd512 : 12'sd0);
    assign comparator_over = $signed({2'b00, dac_code}) > eff;
endmodule : sac_far_model
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the conversion sequencer
`default_nettype none
// ==============================
// Bench
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, nrst = 0, start_pin = 0, range_open = 0;
    logic upper_group_enable_n = 1, lower_group_enable_n = 1;
    logic signed [10:0] vin = 0;
    logic comparator_over, result_valid_n, upper_data_oe, lower_data_oe;
    logic bipolar_offset_on, conv_busy, start_too_short;
    logic [7:0] upper_data;
    logic [1:0] lower_data;
    sac_pkg::sac_word_t dac_code;
    int failures = 0, cmp_count = 0, cyc = 0, seed = 78047, n;
    logic [31:0] r;
    logic signed [10:0] cv [6] = '{0, 1023, 512, 341, -512, 511};
    logic cb [6] = '{0, 0, 0, 0, 1, 1};

    always #10 ref_clk = ~ref_clk;

    sac_sequencer u_sac_sequencer (.ref_clk(ref_clk), .nrst(nrst), .start_pin(start_pin),
        .comparator_over(comparator_over), .range_open(range_open),
        .upper_group_enable_n(upper_group_enable_n), .lower_group_enable_n(lower_group_enable_n),
        .result_valid_n(result_valid_n), .upper_data(upper_data), .upper_data_oe(upper_data_oe),
        .lower_data(lower_data), .lower_data_oe(lower_data_oe), .dac_code(dac_code),
        .bipolar_offset_on(bipolar_offset_on), .conv_busy(conv_busy),
        .start_too_short(start_too_short));
    sac_far_model u_sac_far_model (.dac_code(dac_code), .bipolar_offset_on(bipolar_offset_on),
        .level(vin), .comparator_over(comparator_over));

    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick

    task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [9:0] expect_code(input logic signed [10:0] v, input logic b);
        logic [10:0] t;
        t = v + (b ? 11'sd512 : 11'sd0);
        return t[9:0];
    endfunction : expect_code

    task automatic pulse(input int w);
        n = 99;
        start_pin = 1;
        for (int i = 0; i < w; i++) begin
            tick(1);
            if (result_valid_n === 1'b1 && n == 99) n = i;
        end
        check("ready rise", 1, n < 75);
        check("cleared word", 0, dac_code);
        check("idle while high", 0, conv_busy);
        start_pin = 0;
    endtask : pulse

    task automatic finish(input logic signed [10:0] v, input logic b);
        tick(8);
        check("first trial", 11'h200, dac_code);
        check("search busy", 1, conv_busy);
        check("range latch", b, bipolar_offset_on);
        n = 0;
        while (result_valid_n !== 1'b0 && n < 1200) begin
            tick(1);
            n++;
        end
        check("done in time", 1, n < 1200);
        upper_group_enable_n = 0;
        tick(4);
        check("upper only", 2'b10, {upper_data_oe, lower_data_oe});
        lower_group_enable_n = 0;
        tick(4);
        check("result", expect_code(v, b), {upper_data, lower_data});
        upper_group_enable_n = 1;
        lower_group_enable_n = 1;
        tick(4);
        check("groups off", 0, {upper_data_oe, lower_data_oe});
    endtask : finish

    task automatic run(input logic signed [10:0] v, input logic b, input int w);
        vin = v;
        range_open = b;
        tick(5);
        pulse(w);
        finish(v, b);
    endtask : run

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        tick(4);
        nrst = 1;
        tick(1);
        for (int i = 0; i < 6; i++) run(cv[i], cb[i], i == 0 ? 25 : 40);
        $display("corner codes done");
        run(0, 1, 30);
        check("midscale", 11'h200, {upper_data, lower_data});
        repeat (6) begin
            r = $random(seed);
            run(r[15] ? {r[9], r[9:0]} : {1'b0, r[9:0]}, r[15], 25 + r[20:16]);
        end
        $display("random codes done");
        vin = 100;
        range_open = 0;
        pulse(30);
        tick(350);
        pulse(30);
        finish(100, 0);
        $display("abort done");
        vin = 77;
        pulse(10);
        finish(77, 0);
        check("short flag", 1, start_too_short);
        run(77, 0, 25);
        check("short flag clear", 0, start_too_short);
        $display("short pulse done");
        pulse(30);
        tick(200);
        nrst = 0;
        tick(2);
        check("reset state", 11'h400, {result_valid_n, dac_code});
        check("reset flags", 0, {conv_busy, bipolar_offset_on, start_too_short,
                                 upper_data_oe, lower_data_oe});
        nrst = 1;
        tick(2);
        run(-3, 1, 30);
        $display("mid reset done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
